// ==== insulation_settings_pkg.sv ====
// constants of the insulation monitor settings register bank
package insulation_settings_pkg;

	// register addresses (16-bit register space)
	localparam logic [15:0] ADDR_DISC_INJ_DETECT = 16'h0BD2;
	localparam logic [15:0] ADDR_FAULT_LOC_MODE = 16'h0BD3;
	localparam logic [15:0] ADDR_FAULT_LOC_COUNT = 16'h0BD4;
	localparam logic [15:0] ADDR_RELAY_SELF_TEST = 16'h0BD5;
	localparam logic [15:0] ADDR_GROUND_RES = 16'h0BD6;
	localparam logic [15:0] ADDR_ALARM_ON_INHIBIT = 16'h0BD8;
	localparam logic [15:0] ADDR_SCREEN_SAVER_EN = 16'h0BD9;
	localparam logic [15:0] ADDR_SCREEN_SAVER_DLY = 16'h0BDA;
	localparam logic [15:0] ADDR_INHIBIT_INPUT_EN = 16'h0BDB;
	localparam logic [15:0] ADDR_XFMR_PRIMARY_RES = 16'h0BDC;
	localparam logic [15:0] ADDR_XFMR_COUNT = 16'h0BDD;
	localparam logic [15:0] ADDR_ADAPTER_OFFSET = 16'h0BDE;
	localparam logic [15:0] ADDR_PREV_RELAY_LOGIC = 16'h0BE0;
	localparam logic [15:0] ADDR_PREV_ALARM_DLY = 16'h0BE1;
	localparam logic [15:0] ADDR_MAIN_EVENT_MAP = 16'h0BE4;
	localparam logic [15:0] ADDR_PREV_EVENT_MAP = 16'h0BE6;
	localparam logic [15:0] ADDR_INHIBIT_SOURCE = 16'h0BE8;

	// reset values
	localparam logic [15:0] RST_RELAY_SELF_TEST = 16'h0001;
	localparam logic [31:0] RST_GROUND_RES = 32'h0FFFFFFF;
	localparam logic [15:0] RST_ALARM_ON_INHIBIT = 16'h0001;
	localparam logic [15:0] RST_SCREEN_SAVER_DLY = 16'h012C;
	localparam logic [15:0] RST_PREV_RELAY_LOGIC = 16'h0002;

	// value encodings and limits
	localparam logic [15:0] LOC_MODE_OFF = 16'h0000;
	localparam logic [15:0] LOC_MODE_PORTABLE = 16'h0001;
	localparam logic [15:0] LOC_MODE_FAULT_LOCATOR_UNIT = 16'h0003;
	localparam logic [15:0] FAULT_LOCATOR_UNIT_MAX = 16'h0032;
	localparam logic [15:0] SCREEN_DLY_MIN = 16'h001E;
	localparam logic [15:0] SCREEN_DLY_MAX = 16'h0E10;
	localparam logic [15:0] XFMR_RES_MAX = 16'h0032;
	localparam logic [15:0] RELAY_LOGIC_STANDARD = 16'h0001;
	localparam logic [15:0] RELAY_LOGIC_FAILSAFE = 16'h0002;
	localparam logic [15:0] PREV_DLY_MAX = 16'h1C20;
	localparam logic [31:0] GROUND_RES_MIN = 32'h00000064;
	localparam logic [31:0] GROUND_RES_MAX = 32'h0007A120;
	localparam logic [31:0] GROUND_RES_OFF = 32'h0FFFFFFF;

	// relay event map bit positions
	localparam int EVT_PREVENTIVE = 0;
	localparam int EVT_INSULATION = 4;
	localparam int EVT_INHIBIT = 8;
	localparam int EVT_SYSTEM_ERR = 16;
	localparam int EVT_PRODUCT_ERR = 24;
	localparam logic [31:0] MAIN_MAP_WR_MASK = 32'h01010101;
	localparam logic [31:0] PREV_MAP_WR_MASK = 32'h01010110;

	// exception codes returned on a refused access
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

endpackage : insulation_settings_pkg

// ==== insulation_monitor_settings_bank.sv ====
// settings register bank of the insulation monitor, 16-bit register access port
//////////////////////////////////////////////////////////////////////////////
module insulation_monitor_settings_bank
	import insulation_settings_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register access requests
	input wire logic req,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	// register access answers
	output logic ack,
	output logic [15:0] rdata,
	output logic [7:0] exc_code,
	// live alarm levels shown in the read-only map bits
	input wire logic insulation_alarm,
	input wire logic preventive_alarm,
	// settings towards the monitoring logic
	output logic disc_inj_detect,
	output logic [15:0] fault_locating_mode,
	output logic [15:0] fault_locator_unit_count,
	output logic relay_self_test_enable,
	output logic [31:0] grounding_resistor_value,
	output logic alarm_on_inhibit,
	output logic screen_saver_enable,
	output logic [15:0] screen_saver_delay,
	output logic inhibit_input_enable,
	output logic [15:0] transformer_variant_primary_res,
	output logic [15:0] transformer_variant_count,
	output logic [31:0] adapter_offset_resistance,
	output logic [15:0] preventive_relay_logic,
	output logic [15:0] preventive_alarm_delay,
	output logic [31:0] main_relay_event_map,
	output logic [31:0] preventive_relay_event_map,
	output logic inhibit_source_select
);

	//////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic is_bool(input logic [15:0] v);
		is_bool = (v <= 16'h0001);
	endfunction : is_bool

	// true for the first (high-word) register of a 32-bit setting
	function automatic logic is_pair_head(input logic [15:0] a);
		is_pair_head = (a == ADDR_GROUND_RES) || (a == ADDR_ADAPTER_OFFSET) ||
			(a == ADDR_MAIN_EVENT_MAP) || (a == ADDR_PREV_EVENT_MAP);
	endfunction : is_pair_head

	//////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
		logic [7:0] exc;
		logic disc_inj;
		logic [15:0] loc_mode;
		logic [15:0] loc_count;
		logic self_test;
		logic [31:0] ground_res;
		logic alarm_inh;
		logic ss_en;
		logic [15:0] ss_dly;
		logic inh_en;
		logic [15:0] xfmr_res;
		logic [15:0] xfmr_cnt;
		logic [31:0] adapter;
		logic [15:0] prev_logic;
		logic [15:0] prev_dly;
		logic [31:0] main_map;
		logic [31:0] prev_map;
		logic inh_src;
		logic stage_vld;
		logic [15:0] stage_addr;
		logic [15:0] stage_hi;
	} bank_state_t;

	bank_state_t state_ff;
	bank_state_t nxt_state;

	//////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [31:0] joined;
		logic [15:0] rd;
		logic mapped;
		logic ok;
		joined = {state_ff.stage_hi, wdata};
		rd = 16'h0000;
		mapped = 1'b1;
		ok = 1'b1;
		nxt_state = state_ff;
		nxt_state.ack = 1'b0;
		// read-only bits follow the live alarms, never the bus
		nxt_state.main_map[EVT_INSULATION] = insulation_alarm;
		nxt_state.prev_map[EVT_PREVENTIVE] = preventive_alarm;

		// read mux; reserved bits were never stored so they read zero
		case (addr)
			ADDR_DISC_INJ_DETECT: rd = {15'h0000, state_ff.disc_inj};
			ADDR_FAULT_LOC_MODE: rd = state_ff.loc_mode;
			ADDR_FAULT_LOC_COUNT: rd = state_ff.loc_count;
			ADDR_RELAY_SELF_TEST: rd = {15'h0000, state_ff.self_test};
			ADDR_GROUND_RES: rd = state_ff.ground_res[31:16];
			ADDR_GROUND_RES + 16'h0001: rd = state_ff.ground_res[15:0];
			ADDR_ALARM_ON_INHIBIT: rd = {15'h0000, state_ff.alarm_inh};
			ADDR_SCREEN_SAVER_EN: rd = {15'h0000, state_ff.ss_en};
			ADDR_SCREEN_SAVER_DLY: rd = state_ff.ss_dly;
			ADDR_INHIBIT_INPUT_EN: rd = {15'h0000, state_ff.inh_en};
			ADDR_XFMR_PRIMARY_RES: rd = state_ff.xfmr_res;
			ADDR_XFMR_COUNT: rd = state_ff.xfmr_cnt;
			ADDR_ADAPTER_OFFSET: rd = state_ff.adapter[31:16];
			ADDR_ADAPTER_OFFSET + 16'h0001: rd = state_ff.adapter[15:0];
			ADDR_PREV_RELAY_LOGIC: rd = state_ff.prev_logic;
			ADDR_PREV_ALARM_DLY: rd = state_ff.prev_dly;
			ADDR_MAIN_EVENT_MAP: rd = state_ff.main_map[31:16];
			ADDR_MAIN_EVENT_MAP + 16'h0001: rd = state_ff.main_map[15:0];
			ADDR_PREV_EVENT_MAP: rd = state_ff.prev_map[31:16];
			ADDR_PREV_EVENT_MAP + 16'h0001: rd = state_ff.prev_map[15:0];
			ADDR_INHIBIT_SOURCE: rd = {15'h0000, state_ff.inh_src};
			default: mapped = 1'b0;
		endcase

		if (req) begin
			nxt_state.ack = 1'b1;
			nxt_state.rdata = 16'h0000;
			if (!mapped) begin
				nxt_state.exc = EXC_ILLEGAL_ADDR;
			end else if (!wr) begin
				nxt_state.rdata = rd;
				nxt_state.exc = EXC_NONE;
			end else begin
				// every write to a mapped address drops a staged high half; a pair head then stages its own
				nxt_state.stage_vld = 1'b0;
				if (is_pair_head(addr)) begin
					// high word is held until its partner arrives
					nxt_state.stage_vld = 1'b1;
					nxt_state.stage_addr = addr;
					nxt_state.stage_hi = wdata;
				end else if (is_pair_head(addr - 16'h0001)) begin
					// lone low half is refused so a half-updated value never shows
					ok = state_ff.stage_vld && (state_ff.stage_addr == addr - 16'h0001);
					if (ok) begin
						case (state_ff.stage_addr)
							ADDR_GROUND_RES: begin
								ok = ((joined >= GROUND_RES_MIN) && (joined <= GROUND_RES_MAX)) ||
									(joined == GROUND_RES_OFF);
								if (ok) begin
									nxt_state.ground_res = joined;
								end
							end
							ADDR_ADAPTER_OFFSET: nxt_state.adapter = joined;
							ADDR_MAIN_EVENT_MAP: begin
								nxt_state.main_map = (joined & MAIN_MAP_WR_MASK) |
									(32'h00000001 << EVT_INSULATION) &
									{32{insulation_alarm}};
							end
							ADDR_PREV_EVENT_MAP: begin
								nxt_state.prev_map = (joined & PREV_MAP_WR_MASK) |
									(32'h00000001 << EVT_PREVENTIVE) &
									{32{preventive_alarm}};
							end
							default: ok = 1'b0;
						endcase
					end
				end else begin
					// single-word settings, out-of-range values are refused
					case (addr)
						ADDR_DISC_INJ_DETECT: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.disc_inj = wdata[0];
						end
						ADDR_FAULT_LOC_MODE: begin
							ok = (wdata == LOC_MODE_OFF) || (wdata == LOC_MODE_PORTABLE) ||
								(wdata == LOC_MODE_FAULT_LOCATOR_UNIT);
							if (ok) nxt_state.loc_mode = wdata;
						end
						ADDR_FAULT_LOC_COUNT: begin
							ok = (wdata <= FAULT_LOCATOR_UNIT_MAX);
							if (ok) nxt_state.loc_count = wdata;
						end
						ADDR_RELAY_SELF_TEST: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.self_test = wdata[0];
						end
						ADDR_ALARM_ON_INHIBIT: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.alarm_inh = wdata[0];
						end
						ADDR_SCREEN_SAVER_EN: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.ss_en = wdata[0];
						end
						ADDR_SCREEN_SAVER_DLY: begin
							ok = in_range(wdata, SCREEN_DLY_MIN, SCREEN_DLY_MAX);
							if (ok) nxt_state.ss_dly = wdata;
						end
						ADDR_INHIBIT_INPUT_EN: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.inh_en = wdata[0];
						end
						ADDR_XFMR_PRIMARY_RES: begin
							ok = (wdata <= XFMR_RES_MAX);
							if (ok) nxt_state.xfmr_res = wdata;
						end
						ADDR_XFMR_COUNT: begin
							ok = (wdata == 16'h0000) || (wdata == 16'h0001) ||
								(wdata == 16'h0003);
							if (ok) nxt_state.xfmr_cnt = wdata;
						end
						ADDR_PREV_RELAY_LOGIC: begin
							ok = in_range(wdata, RELAY_LOGIC_STANDARD,
								RELAY_LOGIC_FAILSAFE);
							if (ok) nxt_state.prev_logic = wdata;
						end
						ADDR_PREV_ALARM_DLY: begin
							ok = (wdata <= PREV_DLY_MAX);
							if (ok) nxt_state.prev_dly = wdata;
						end
						ADDR_INHIBIT_SOURCE: begin
							ok = is_bool(wdata);
							if (ok) nxt_state.inh_src = wdata[0];
						end
						default: ok = 1'b0;
					endcase
				end
				nxt_state.exc = ok ? EXC_NONE : EXC_ILLEGAL_VALUE;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= '0;
			state_ff.loc_mode <= LOC_MODE_OFF;
			state_ff.self_test <= RST_RELAY_SELF_TEST[0];
			state_ff.ground_res <= RST_GROUND_RES;
			state_ff.alarm_inh <= RST_ALARM_ON_INHIBIT[0];
			state_ff.ss_dly <= RST_SCREEN_SAVER_DLY;
			state_ff.prev_logic <= RST_PREV_RELAY_LOGIC;
		end else begin
			state_ff <= nxt_state;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// outputs, all taken from the state register

	assign ack = state_ff.ack;
	assign rdata = state_ff.rdata;
	assign exc_code = state_ff.exc;
	assign disc_inj_detect = state_ff.disc_inj;
	assign fault_locating_mode = state_ff.loc_mode;
	assign fault_locator_unit_count = state_ff.loc_count;
	assign relay_self_test_enable = state_ff.self_test;
	assign grounding_resistor_value = state_ff.ground_res;
	assign alarm_on_inhibit = state_ff.alarm_inh;
	assign screen_saver_enable = state_ff.ss_en;
	assign screen_saver_delay = state_ff.ss_dly;
	assign inhibit_input_enable = state_ff.inh_en;
	assign transformer_variant_primary_res = state_ff.xfmr_res;
	assign transformer_variant_count = state_ff.xfmr_cnt;
	assign adapter_offset_resistance = state_ff.adapter;
	assign preventive_relay_logic = state_ff.prev_logic;
	assign preventive_alarm_delay = state_ff.prev_dly;
	assign main_relay_event_map = state_ff.main_map;
	assign preventive_relay_event_map = state_ff.prev_map;
	assign inhibit_source_select = state_ff.inh_src;

endmodule : insulation_monitor_settings_bank

// ==== insulation_settings_chk.sv ====
// assertion checker of the settings register bank ports
module insulation_settings_chk
	import insulation_settings_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// access port
	input wire logic req,
	input wire logic wr,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [7:0] exc_code,
	// live alarms and settings
	input wire logic insulation_alarm,
	input wire logic preventive_alarm,
	input wire logic relay_self_test_enable,
	input wire logic [15:0] fault_locating_mode,
	input wire logic [15:0] fault_locator_unit_count,
	input wire logic [15:0] screen_saver_delay,
	input wire logic [15:0] preventive_relay_logic,
	input wire logic [15:0] preventive_alarm_delay,
	input wire logic [31:0] grounding_resistor_value,
	input wire logic [31:0] main_relay_event_map,
	input wire logic [31:0] preventive_relay_event_map
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_loc_mode_codes: assert property (fault_locating_mode inside {16'h0000, 16'h0001, 16'h0003})
		else $error("locator mode outside its codes");
	a_loc_count_max: assert property (fault_locator_unit_count <= 16'h0032)
		else $error("locator count above fifty");
	a_self_test_refuse: assert property (req && wr && addr == ADDR_RELAY_SELF_TEST && wdata > 16'h0001
		|=> exc_code == EXC_ILLEGAL_VALUE && $stable(relay_self_test_enable)) else $error("bad self test");
	a_ground_res_legal: assert property (grounding_resistor_value == 32'h0FFFFFFF ||
		grounding_resistor_value inside {[32'h00000064:32'h0007A120]}) else $error("resistance illegal");
	a_ss_delay_range: assert property (screen_saver_delay inside {[16'h001E:16'h0E10]})
		else $error("screen delay out of range");
	a_relay_logic_codes: assert property (preventive_relay_logic inside {16'h0001, 16'h0002})
		else $error("relay logic code illegal");
	a_prev_delay_max: assert property (preventive_alarm_delay <= 16'h1C20)
		else $error("preventive delay too long");
	a_main_ro_track: assert property (1'b1 |=> main_relay_event_map[4] == $past(insulation_alarm))
		else $error("main map bit four not live");
	a_prev_ro_track: assert property (1'b1 |=> preventive_relay_event_map[0] == $past(preventive_alarm))
		else $error("preventive map bit zero not live");
	a_reserved_zero: assert property (((main_relay_event_map | preventive_relay_event_map)
		& 32'hFEFEFEEE) == 32'h00000000) else $error("reserved map bit set");
	c_value_refused: cover property (ack && exc_code == EXC_ILLEGAL_VALUE);
	c_addr_refused: cover property (ack && exc_code == EXC_ILLEGAL_ADDR);
	c_map_alarm: cover property (insulation_alarm ##1 main_relay_event_map[4]);
endmodule : insulation_settings_chk

bind insulation_monitor_settings_bank insulation_settings_chk i_chk (.clk(clk), .arst_n(arst_n),
	.req(req), .wr(wr), .addr(addr), .wdata(wdata), .ack(ack), .exc_code(exc_code),
	.insulation_alarm(insulation_alarm), .preventive_alarm(preventive_alarm),
	.relay_self_test_enable(relay_self_test_enable), .fault_locating_mode(fault_locating_mode),
	.fault_locator_unit_count(fault_locator_unit_count), .screen_saver_delay(screen_saver_delay),
	.preventive_relay_logic(preventive_relay_logic), .preventive_alarm_delay(preventive_alarm_delay),
	.grounding_resistor_value(grounding_resistor_value), .main_relay_event_map(main_relay_event_map),
	.preventive_relay_event_map(preventive_relay_event_map));

// ==== settings_master.sv ====
// register access master model facing the settings bank
module settings_master (
	// clock
	input wire logic clk,
	// requests
	output logic req,
	output logic wr,
	output logic [15:0] addr,
	output logic [15:0] wdata,
	// answers
	input wire logic ack,
	input wire logic [15:0] rdata,
	input wire logic [7:0] exc_code
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		req = 1'b0;
		wr = 1'b0;
		addr = 16'h0000;
		wdata = 16'h0000;
	end
	task automatic access(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic [7:0] e);
		q = 16'hFFFF;
		e = 8'hFF;
		@(posedge clk);
		#1;
		req = 1'b1;
		wr = w;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		req = 1'b0;
		// released lines show the inverse so a stale value cannot pass
		wr = ~w;
		addr = ~a;
		wdata = ~d;
		// the answer is registered on the taking edge, so it is settled one step later
		for (int n = 0; n < 4; n++) begin
			if (ack === 1'b1) begin
				q = rdata;
				e = exc_code;
				break;
			end
			@(posedge clk);
			#1;
		end
	endtask : access
	// both halves always go out, high word at the lower address
	task automatic write32(input logic [15:0] a, input logic [31:0] v, output logic [7:0] e);
		logic [15:0] q;
		access(1'b1, a, v[31:16], q, e);
		access(1'b1, a + 16'h0001, v[15:0], q, e);
	endtask : write32
endmodule : settings_master

// ==== tb.sv ====
// self-checking bench of the settings register bank
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb
	import insulation_settings_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, arst_n = 1'b0, req, wr, ack, ins_al = 1'b0, prv_al = 1'b0, self_t, iss;
	logic [15:0] addr, wdata, rdata, loc_mode, ss_dly, rl_logic;
	logic [7:0] exc_code, e;
	logic [15:0] q;
	logic [31:0] gres, adapt, mmap, pmap;
	logic disc_o, aoi, sse, iie;
	logic [15:0] loc_cnt, xres, xcnt, pdly;
	int err_total = 0, n_checks = 0;
	localparam logic [15:0] RA [17] = '{16'h0BD2, 16'h0BD3, 16'h0BD4, 16'h0BD5, 16'h0BD6, 16'h0BD7,
		16'h0BD8, 16'h0BD9, 16'h0BDA, 16'h0BDB, 16'h0BDC, 16'h0BDD, 16'h0BDE, 16'h0BDF, 16'h0BE0,
		16'h0BE1, 16'h0BE8};
	localparam logic [15:0] RV [17] = '{16'h0000, 16'h0000, 16'h0000, 16'h0001, 16'h0FFF, 16'hFFFF,
		16'h0001, 16'h0000, 16'h012C, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002,
		16'h0000, 16'h0000};
	always #5 clk = ~clk;
	settings_master host (.clk(clk), .req(req), .wr(wr), .addr(addr), .wdata(wdata), .ack(ack),
		.rdata(rdata), .exc_code(exc_code));
	insulation_monitor_settings_bank i_insulation_monitor_settings_bank (.clk(clk), .arst_n(arst_n),
		.req(req), .wr(wr), .addr(addr), .wdata(wdata), .ack(ack), .rdata(rdata), .exc_code(exc_code),
		.insulation_alarm(ins_al), .preventive_alarm(prv_al), .disc_inj_detect(disc_o),
		.fault_locating_mode(loc_mode), .fault_locator_unit_count(loc_cnt),
		.relay_self_test_enable(self_t), .grounding_resistor_value(gres), .alarm_on_inhibit(aoi),
		.screen_saver_enable(sse), .screen_saver_delay(ss_dly), .inhibit_input_enable(iie),
		.transformer_variant_primary_res(xres), .transformer_variant_count(xcnt),
		.adapter_offset_resistance(adapt), .preventive_relay_logic(rl_logic),
		.preventive_alarm_delay(pdly), .main_relay_event_map(mmap),
		.preventive_relay_event_map(pmap), .inhibit_source_select(iss));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk_rd(input logic [15:0] a, input logic [15:0] x);
		host.access(1'b0, a, 16'h0000, q, e);
		`CHK(e, EXC_NONE)
		`CHK(q, x)
	endtask : chk_rd
	task automatic chk_wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] x,
		input logic [15:0] back);
		host.access(1'b1, a, d, q, e);
		`CHK(e, x)
		chk_rd(a, back);
	endtask : chk_wr
	task automatic t_reset;
		for (int i = 0; i < 17; i++) chk_rd(RA[i], RV[i]);
		`CHK({self_t, gres, ss_dly, rl_logic}, {1'b1, 32'h0FFFFFFF, 16'h012C, 16'h0002})
		`CHK({disc_o, aoi, sse, iie, iss}, {1'b0, 1'b1, 1'b0, 1'b0, 1'b0})
		`CHK({loc_mode, loc_cnt, xres, xcnt, pdly}, 80'h0)
		`CHK({adapt, mmap, pmap}, 96'h0)
		$display("test reset done");
	endtask : t_reset
	task automatic t_codes;
		chk_wr(16'h0BD2, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BD2, 16'h0002, 8'h03, 16'h0001);
		chk_wr(16'h0BD3, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BD3, 16'h0003, 8'h00, 16'h0003);
		chk_wr(16'h0BD3, 16'h0002, 8'h03, 16'h0003);
		chk_wr(16'h0BD4, 16'h0032, 8'h00, 16'h0032);
		chk_wr(16'h0BD4, 16'h0033, 8'h03, 16'h0032);
		chk_wr(16'h0BD5, 16'h0000, 8'h00, 16'h0000);
		chk_wr(16'h0BD5, 16'h0002, 8'h03, 16'h0000);
		chk_wr(16'h0BD8, 16'h0000, 8'h00, 16'h0000);
		chk_wr(16'h0BD9, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BDA, 16'h001D, 8'h03, 16'h012C);
		chk_wr(16'h0BDA, 16'h001E, 8'h00, 16'h001E);
		chk_wr(16'h0BDA, 16'h0E11, 8'h03, 16'h001E);
		chk_wr(16'h0BDA, 16'h0E10, 8'h00, 16'h0E10);
		chk_wr(16'h0BDC, 16'h0033, 8'h03, 16'h0000);
		chk_wr(16'h0BDC, 16'h0032, 8'h00, 16'h0032);
		chk_wr(16'h0BDD, 16'h0003, 8'h00, 16'h0003);
		chk_wr(16'h0BDD, 16'h0002, 8'h03, 16'h0003);
		chk_wr(16'h0BE0, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BE0, 16'h0003, 8'h03, 16'h0001);
		chk_wr(16'h0BE1, 16'h1C20, 8'h00, 16'h1C20);
		chk_wr(16'h0BE1, 16'h1C21, 8'h03, 16'h1C20);
		chk_wr(16'h0BDB, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BE8, 16'h0001, 8'h00, 16'h0001);
		chk_wr(16'h0BE8, 16'h0002, 8'h03, 16'h0001);
		`CHK({loc_mode, ss_dly, rl_logic, iss}, {16'h0003, 16'h0E10, 16'h0001, 1'b1})
		`CHK({disc_o, aoi, sse, iie, self_t}, {1'b1, 1'b0, 1'b1, 1'b1, 1'b0})
		`CHK({loc_cnt, xres, xcnt, pdly}, {16'h0032, 16'h0032, 16'h0003, 16'h1C20})
		$display("test codes done");
	endtask : t_codes
	task automatic t_wide;
		host.write32(ADDR_GROUND_RES, 32'h000186A0, e);
		`CHK({e, gres}, {8'h00, 32'h000186A0})
		chk_rd(16'h0BD6, 16'h0001);
		chk_rd(16'h0BD7, 16'h86A0);
		host.write32(ADDR_GROUND_RES, 32'h00000063, e);
		`CHK({e, gres}, {8'h03, 32'h000186A0})
		host.write32(ADDR_GROUND_RES, 32'h0FFFFFFF, e);
		`CHK({e, gres}, {8'h00, 32'h0FFFFFFF})
		host.access(1'b1, 16'h0BDE, 16'h4000, q, e);
		`CHK({e, adapt}, {8'h00, 32'h00000000})
		host.access(1'b1, 16'h0BD9, 16'h0000, q, e);
		host.access(1'b1, 16'h0BDF, 16'h1234, q, e);
		`CHK({e, adapt}, {8'h03, 32'h00000000})
		host.write32(ADDR_ADAPTER_OFFSET, 32'h3F800000, e);
		`CHK({e, adapt}, {8'h00, 32'h3F800000})
		$display("test wide done");
	endtask : t_wide
	task automatic t_maps;
		host.write32(ADDR_MAIN_EVENT_MAP, 32'hFFFFFFFF, e);
		`CHK({e, mmap}, {8'h00, 32'h01010101})
		ins_al = 1'b1;
		chk_rd(16'h0BE5, 16'h0111);
		host.write32(ADDR_MAIN_EVENT_MAP, 32'h00000000, e);
		`CHK(mmap, 32'h00000010)
		host.write32(ADDR_PREV_EVENT_MAP, 32'hFFFFFFFF, e);
		`CHK({e, pmap}, {8'h00, 32'h01010110})
		prv_al = 1'b1;
		chk_rd(16'h0BE7, 16'h0111);
		host.write32(ADDR_PREV_EVENT_MAP, 32'h00000000, e);
		`CHK(pmap, 32'h00000001)
		host.access(1'b0, 16'h0BE2, 16'h0000, q, e);
		`CHK(e, EXC_ILLEGAL_ADDR)
		$display("test maps done");
	endtask : t_maps
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#100us;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 arst_n = 1'b1;
		t_reset();
		t_codes();
		t_wide();
		t_maps();
		report_and_stop();
	end
endmodule : tb
